// ---- pwr_seq_pkg.sv ----
package pwr_seq_pkg;
    // ========================================================
    // register map (byte offsets, decoded on haddr[7:0])
    localparam int IO_N = 16;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_WAKE_EN = 8'h08;
    localparam logic [7:0] A_IO_EDGE = 8'h0C;
    localparam logic [7:0] A_FLAGS = 8'h10;
    localparam logic [7:0] A_CMP = 8'h14;
    localparam logic [7:0] A_TMR_BASE = 8'h18;
    localparam logic [7:0] A_TMR_STRIDE = 8'h08;
    localparam logic [7:0] A_TMR_HI_OFS = 8'h04;
    localparam logic [7:0] A_PC_BASE = 8'h28;
    localparam logic [7:0] A_PC_STRIDE = 8'h04;
    // ========================================================
    // control register fields
    localparam int C_SLEEP = 0;
    localparam int C_DEEP = 1;
    localparam int C_DOZE = 2;
    localparam int C_RAM = 3;
    localparam int C_ANA = 4;
    localparam int C_OSCOFF = 5;
    localparam int C_TMROFF = 6;
    localparam logic [6:0] CTRL_RST = 7'h00;
    // wake flag / enable layout
    localparam int F_IO = 0;
    localparam int F_TMR = 16;
    localparam int F_PC = 18;
    localparam int F_CMP = 20;
    localparam int F_W = 22;
    localparam logic [F_W-1:0] WAKE_EN_RST = 22'h000000;
    // status fields
    localparam int S_FROM_SLEEP = 6;
    localparam int S_CMP_LVL = 7;
    // timers and pulse counters
    localparam int TMR_W = 35;
    localparam int PC_W = 16;
    localparam int PC_DB = 16;
    // comparator negative input choices and hysteresis codes
    localparam logic [1:0] NEG_VREF = 2'h0;
    localparam logic [1:0] NEG_DAC = 2'h1;
    localparam logic [1:0] NEG_PIN = 2'h2;
    localparam logic [1:0] HYST_0MV = 2'h0;
    localparam logic [1:0] HYST_10MV = 2'h1;
    localparam logic [1:0] HYST_20MV = 2'h2;
    localparam logic [1:0] HYST_40MV = 2'h3;
    localparam logic [11:0] CMP_RST = 12'h000;

    typedef enum logic [5:0] {
        ST_ACTIVE = 6'h01,
        ST_DOZE = 6'h02,
        ST_SLEEP = 6'h04,
        ST_BOD = 6'h08,
        ST_OSC = 6'h10,
        ST_DEEP = 6'h20
    } state_t;

    typedef struct packed {
        logic bod_check;
        logic wake_timers;
        logic osc32m;
        logic osc32k;
        logic radio;
        logic ram;
        logic analog;
        logic digital;
    } pwr_t;

    typedef struct packed {
        logic [1:0] rise;
        logic [1:0] lowpwr;
        logic [1:0] en;
        logic [1:0] second_comparator_negative_input;
        logic [1:0] first_comparator_negative_input;
        logic [1:0] hyst;
    } cmp_cfg_t;
endpackage : pwr_seq_pkg

// ---- sleep_wake_power_controller.sv ----
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - always-on parts stay up; timers/oscillator switchable
// - digital domain off whenever asleep
// - analogue off asleep, software-switched when active
// - RAM kept in sleep only if retention chosen
// - radio powered only on baseband request, awake
// - doze halts CPU; any interrupt ends it
// - sleep only on software request; pins held
// - converter outputs high impedance during sleep
// - stopped 32k oscillator restarts on wake event
// - wake only from enabled timer/io/counter/comparator
// - wake: brown-out check, 32M start, release reset
// - two 35-bit timers on 32k, free running
// - any io edge, chosen polarity, can wake
// - comparator edge, chosen polarity, can wake
// - shared hysteresis: 0, 10, 20, 40 mV
// - negative input: reference, converter, or pin
// - comparator levels readable; enable, low-power mode
// - two 16-bit pulse counters never stop
// - counters wake without 32k unless debounced
// - deep sleep stops all; io event resets chip
module sleep_wake_power_controller
    import pwr_seq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [IO_N-1:0] io_in,
    input wire logic [1:0] cmp_raw,
    input wire logic [1:0] pulse_in,
    input wire logic tick_32k,
    input wire logic bod_ok,
    input wire logic osc32m_stable,
    input wire logic radio_req,
    input wire logic irq_req,
    output pwr_t pwr,
    output cmp_cfg_t cmp_cfg,
    output logic cpu_halt,
    output logic cpu_reset_n,
    output logic io_hold,
    output logic dac_hiz,
    output logic chip_reset_req
);
    localparam int AW = IO_N + 7;

    // ========================================================
    // pin synchronisers
    logic [AW-1:0] sync1_reg;
    logic [AW-1:0] sync2_reg;
    logic [AW-1:0] prev_reg;
    logic [IO_N-1:0] io_s;
    logic [1:0] cmp_s;
    logic [1:0] pulse_s;
    logic tick_s;
    logic bod_s;
    logic osc_s;

    // stage one feeds stage two only; edges compare stage two to prev
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
        end else begin
            sync1_reg <= {osc32m_stable, bod_ok, tick_32k, pulse_in, cmp_raw, io_in};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end
    assign {osc_s, bod_s, tick_s, pulse_s, cmp_s, io_s} = sync2_reg;

    // ========================================================
    // AHB-Lite slave: zero wait, always OKAY
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic addr_ok;
    logic [31:0] rd_val;
    assign addr_ok = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // write data arrives one cycle after its address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok & hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    logic wr_ctrl;
    logic wr_stat;
    logic wr_flags;
    assign wr_ctrl = wr_pend_reg && wr_addr_reg == A_CTRL;
    assign wr_stat = wr_pend_reg && wr_addr_reg == A_STATUS;
    assign wr_flags = wr_pend_reg && wr_addr_reg == A_FLAGS;

    // ========================================================
    // configuration registers
    logic [6:0] ctrl_reg;
    logic [F_W-1:0] wake_en_reg;
    logic [IO_N-1:0] io_edge_reg;
    cmp_cfg_t cmp_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RST;
            wake_en_reg <= WAKE_EN_RST;
            io_edge_reg <= '0;
            cmp_reg <= CMP_RST;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == A_CTRL)
                ctrl_reg <= {hwdata[6:3], 3'h0}; // request bits never stored
            if (wr_addr_reg == A_WAKE_EN)
                wake_en_reg <= hwdata[F_W-1:0];
            if (wr_addr_reg == A_IO_EDGE)
                io_edge_reg <= hwdata[IO_N-1:0];
            if (wr_addr_reg == A_CMP)
                cmp_reg <= hwdata[11:0];
        end
    end
    assign cmp_cfg = cmp_reg;

    // ========================================================
    // state machine
    state_t state_reg;
    state_t state_next;
    logic [F_W-1:0] flags_reg;
    logic wake_hit;
    logic io_hit;
    logic sleep_wr;
    assign wake_hit = |(flags_reg & wake_en_reg);
    assign io_hit = |(flags_reg[F_IO+:IO_N] & wake_en_reg[F_IO+:IO_N]);
    assign sleep_wr = wr_ctrl & hwdata[C_SLEEP];

    // leftover pending flags make a fresh sleep end at once
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_ACTIVE: begin
                if (wr_ctrl & hwdata[C_DEEP])
                    state_next = ST_DEEP;
                else if (sleep_wr)
                    state_next = ST_SLEEP;
                else if (wr_ctrl & hwdata[C_DOZE])
                    state_next = ST_DOZE;
            end
            ST_DOZE: begin
                if (irq_req)
                    state_next = ST_ACTIVE;
            end
            ST_SLEEP: begin
                if (wake_hit)
                    state_next = ST_BOD;
            end
            ST_BOD: begin
                if (bod_s)
                    state_next = ST_OSC;
            end
            ST_OSC: begin
                if (osc_s)
                    state_next = ST_ACTIVE;
            end
            ST_DEEP: state_next = ST_DEEP; // left only by chip reset
            default: state_next = ST_ACTIVE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            state_reg <= ST_ACTIVE;
        else
            state_reg <= state_next;
    end

    // ========================================================
    // power and hold outputs, decoded from the state flops together with ctrl_reg bits, radio_req, wake_hit and io_hit
    logic run;
    logic asleep;
    logic waking;
    assign run = state_reg == ST_ACTIVE || state_reg == ST_DOZE;
    assign asleep = state_reg == ST_SLEEP;
    assign waking = state_reg == ST_BOD || state_reg == ST_OSC;

    always_comb begin
        pwr = '0;
        pwr.digital = run;
        pwr.analog = run & ctrl_reg[C_ANA];
        pwr.ram = run | ((asleep | waking) & ctrl_reg[C_RAM]);
        pwr.radio = run & radio_req;
        // a wake event reopens the oscillator in the same cycle
        pwr.osc32k = state_reg != ST_DEEP &&
            !(asleep & ctrl_reg[C_OSCOFF] & !wake_hit);
        pwr.wake_timers = state_reg != ST_DEEP &&
            !(asleep & ctrl_reg[C_TMROFF] & !wake_hit);
        pwr.osc32m = run | state_reg == ST_OSC;
        pwr.bod_check = state_reg == ST_BOD;
    end
    assign cpu_halt = state_reg == ST_DOZE;
    assign cpu_reset_n = run;
    assign io_hold = asleep | waking | state_reg == ST_DEEP;
    assign dac_hiz = !run;
    assign chip_reset_req = state_reg == ST_DEEP && io_hit;

    // ========================================================
    // 32k tick, only counted while the oscillator runs
    logic tick_ok;
    // the tick sits at bit IO_N+4 of the synchroniser word, above the pulse inputs
    assign tick_ok = tick_s & ~prev_reg[IO_N+4] & pwr.osc32k & pwr.wake_timers;

    // ========================================================
    // io and comparator edge events
    logic [IO_N-1:0] io_evt;
    logic [1:0] cmp_evt;
    logic [1:0] tmr_evt;
    logic [1:0] pc_evt;
    // alternate pin functions do not block the edge detector
    assign io_evt = (io_s & ~prev_reg[IO_N-1:0] & io_edge_reg) |
        (~io_s & prev_reg[IO_N-1:0] & ~io_edge_reg);
    assign cmp_evt = cmp_reg.en & ((cmp_s & ~prev_reg[IO_N+:2] & cmp_reg.rise) |
        (~cmp_s & prev_reg[IO_N+:2] & ~cmp_reg.rise));

    // ========================================================
    // wakeup timers and pulse counters, one pair each
    logic [TMR_W-1:0] tmr_cnt [2];
    logic [PC_W-1:0] pc_cnt [2];
    logic [1:0] pc_db;

    for (genvar i = 0; i < 2; i++) begin : g_src
        localparam logic [7:0] TLO = 8'(A_TMR_BASE + A_TMR_STRIDE * 8'(i));
        localparam logic [7:0] THI = 8'(TLO + A_TMR_HI_OFS);
        localparam logic [7:0] PAD = 8'(A_PC_BASE + A_PC_STRIDE * 8'(i));
        logic [TMR_W-1:0] tmr_reg;
        logic [PC_W-1:0] pc_reg;
        logic [PC_W-1:0] thr_reg;
        logic db_reg;
        logic samp_reg;
        logic stable_reg;
        logic stable_prev_reg;
        logic pin_lvl;
        logic pin_prev;

        // down-counter: expiry at one-to-zero, then it keeps wrapping
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
                tmr_reg <= '0;
            else if (wr_pend_reg && wr_addr_reg == TLO)
                tmr_reg <= {tmr_reg[TMR_W-1:32], hwdata};
            else if (wr_pend_reg && wr_addr_reg == THI)
                tmr_reg <= {hwdata[TMR_W-33:0], tmr_reg[31:0]};
            else if (tick_ok)
                tmr_reg <= tmr_reg - TMR_W'(1);
        end
        assign tmr_evt[i] = tick_ok && tmr_reg == TMR_W'(1);
        assign tmr_cnt[i] = tmr_reg;

        // debounce samples on the 32k tick, so it needs the oscillator
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                samp_reg <= 1'b0;
                stable_reg <= 1'b0;
            end else if (tick_ok) begin
                samp_reg <= pulse_s[i];
                if (samp_reg == pulse_s[i])
                    stable_reg <= pulse_s[i];
            end
        end
        assign pin_lvl = db_reg ? stable_reg : pulse_s[i];

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
                stable_prev_reg <= 1'b0;
            else
                stable_prev_reg <= stable_reg;
        end
        assign pin_prev = db_reg ? stable_prev_reg : prev_reg[IO_N+2+i];

        // counts in every state, wake sequence included
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pc_reg <= '0;
                thr_reg <= '0;
                db_reg <= 1'b0;
            end else if (wr_pend_reg && wr_addr_reg == PAD) begin
                pc_reg <= '0;
                thr_reg <= hwdata[PC_W-1:0];
                db_reg <= hwdata[PC_DB];
            end else if (pin_lvl & ~pin_prev) begin
                pc_reg <= pc_reg + PC_W'(1);
            end
        end
        assign pc_evt[i] = pin_lvl && !pin_prev && !(wr_pend_reg && wr_addr_reg == PAD)
            && pc_reg + PC_W'(1) == thr_reg;
        assign pc_cnt[i] = pc_reg;
        assign pc_db[i] = db_reg;
    end

    // ========================================================
    // sticky wake flags: write one clears, a new event wins
    logic [F_W-1:0] flag_set;
    logic [F_W-1:0] flag_clr;
    assign flag_set = {cmp_evt, pc_evt, tmr_evt, io_evt};
    assign flag_clr = wr_flags ? hwdata[F_W-1:0] : '0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            flags_reg <= '0;
        else
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
    end

    // reset-from-sleep marker for the boot code
    logic from_sleep_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            from_sleep_reg <= 1'b0;
        else if (state_reg == ST_OSC && osc_s)
            from_sleep_reg <= 1'b1;
        else if (wr_stat & hwdata[S_FROM_SLEEP])
            from_sleep_reg <= 1'b0;
    end

    // ========================================================
    // read mux, registered into the data phase
    always_comb begin
        rd_val = 32'h0000_0000;
        case (haddr[7:0])
            A_CTRL: rd_val = {25'h0, ctrl_reg};
            A_STATUS: rd_val = {23'h0, cmp_s, from_sleep_reg, state_reg};
            A_WAKE_EN: rd_val = {10'h0, wake_en_reg};
            A_IO_EDGE: rd_val = {16'h0, io_edge_reg};
            A_FLAGS: rd_val = {10'h0, flags_reg};
            A_CMP: rd_val = {20'h0, cmp_reg};
            8'h18: rd_val = tmr_cnt[0][31:0];
            8'h1C: rd_val = {29'h0, tmr_cnt[0][TMR_W-1:32]};
            8'h20: rd_val = tmr_cnt[1][31:0];
            8'h24: rd_val = {29'h0, tmr_cnt[1][TMR_W-1:32]};
            8'h28: rd_val = {15'h0, pc_db[0], pc_cnt[0]};
            8'h2C: rd_val = {15'h0, pc_db[1], pc_cnt[1]};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (addr_ok & ~hwrite)
            hrdata <= rd_val;
    end

    // ========================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_digital_off_sleep: assert property (asleep |-> !pwr.digital && cpu_reset_n == 1'b0)
        else $error("digital domain powered in sleep");
    a_analog_sw_ctrl: assert property (run |-> pwr.analog == ctrl_reg[C_ANA])
        else $error("analogue power not following software");
    a_ram_retention: assert property (asleep |-> pwr.ram == ctrl_reg[C_RAM])
        else $error("ram power wrong in sleep");
    a_radio_gate: assert property (pwr.radio |-> radio_req && run)
        else $error("radio powered without request");
    a_doze_exit: assert property (state_reg == ST_DOZE && irq_req |=> run && !cpu_halt)
        else $error("interrupt did not end doze");
    a_sleep_entry: assert property ($rose(asleep) |-> $past(sleep_wr))
        else $error("sleep entered without request");
    a_dac_hold: assert property (asleep |-> dac_hiz && io_hold)
        else $error("outputs not held in sleep");
    a_osc_restart: assert property (asleep && wake_hit |-> pwr.osc32k ##1 state_reg == ST_BOD)
        else $error("oscillator not restarted on wake");
    a_wake_only_enabled: assert property (asleep && !wake_hit |=> asleep)
        else $error("woke without enabled source");
    a_wake_sequence: assert property (state_reg == ST_OSC && osc_s |=> run && from_sleep_reg)
        else $error("wake did not release reset");
    a_deep_off: assert property (state_reg == ST_DEEP |-> !pwr.osc32k && !pwr.digital)
        else $error("domain running in deep sleep");
    a_flag_sticky: assert property (tmr_evt[0] |=> flags_reg[F_TMR])
        else $error("timer flag not latched");

    c_doze_round: cover property (state_reg == ST_DOZE ##1 state_reg == ST_ACTIVE);
    c_sleep_wake: cover property (asleep ##1 state_reg == ST_BOD ##[1:20] from_sleep_reg);
    c_deep_reset: cover property (chip_reset_req);
    c_pulse_wake: cover property (asleep && pc_evt[0]);
endmodule : sleep_wake_power_controller

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
    import pwr_seq_pkg::*;
    // ========================================================
    // signals driven by the bench, outputs of the controller
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic [IO_N-1:0] io_in = 16'h0004; // pin 2 idles high for a falling-edge wake
    logic [1:0] cmp_raw = 2'h0;
    logic [1:0] pulse_in = 2'h0;
    logic tick_32k = 1'b0;
    logic bod_ok = 1'b0;
    logic osc32m_stable = 1'b0;
    logic radio_req = 1'b0;
    logic irq_req = 1'b0;
    pwr_t pwr;
    cmp_cfg_t cmp_cfg;
    logic cpu_halt;
    logic cpu_reset_n;
    logic io_hold;
    logic dac_hiz;
    logic chip_reset_req;
    logic [31:0] rv;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    always #4 hclk = ~hclk;

    sleep_wake_power_controller u_sleep_wake_power_controller (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .io_in(io_in),
        .cmp_raw(cmp_raw), .pulse_in(pulse_in), .tick_32k(tick_32k), .bod_ok(bod_ok),
        .osc32m_stable(osc32m_stable), .radio_req(radio_req), .irq_req(irq_req),
        .pwr(pwr), .cmp_cfg(cmp_cfg), .cpu_halt(cpu_halt), .cpu_reset_n(cpu_reset_n),
        .io_hold(io_hold), .dac_hiz(dac_hiz), .chip_reset_req(chip_reset_req)
    );

    // ========================================================
    // shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // one single transfer; the master waits on hreadyout rather than assuming zero waits
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
        #1;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask : rd

    // look just after an edge so the edge's updates have landed
    task automatic step(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : step

    // sel 0 pulses the 32k tick, sel 1 the first pulse counter input
    task automatic strobe(input int sel, input int n);
        repeat (n) begin
            @(posedge hclk);
            if (sel == 0) tick_32k <= 1'b1;
            else pulse_in[0] <= 1'b1;
            repeat (4) @(posedge hclk);
            if (sel == 0) tick_32k <= 1'b0;
            else pulse_in[0] <= 1'b0;
            step(4);
        end
    endtask : strobe

    // bounded wait for the wake sequence to hand the cpu back
    task automatic wait_awake;
        for (int i = 0; i < 40 && cpu_reset_n !== 1'b1; i++) step(1);
        chk({31'h0, cpu_reset_n}, 32'h1);
    endtask : wait_awake

    // ========================================================
    // scenarios
    task automatic t_reset;
        chk({24'h0, pwr}, 32'h75);
        chk({28'h0, cpu_reset_n, cpu_halt, io_hold, dac_hiz}, 32'h8);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        rd(A_CTRL);
        chk(rv, 32'h0);
        rd(8'h3C);
        chk(rv, 32'h0);
        wr(A_CTRL, 32'h10);
        @(posedge hclk);
        radio_req <= 1'b1;
        step(2);
        chk({30'h0, pwr.analog, pwr.radio}, 32'h3);
        $display("test reset and active done");
    endtask : t_reset

    task automatic t_sleep_io;
        wr(A_IO_EDGE, 32'h3);
        wr(A_WAKE_EN, 32'h1);
        wr(A_CTRL, 32'h39); // sleep with retention, analogue on and 32k off
        step(2);
        chk({28'h0, pwr.digital, pwr.analog, pwr.ram, pwr.radio}, 32'h2);
        chk({28'h0, pwr.osc32k, io_hold, dac_hiz, cpu_reset_n}, 32'h6);
        @(posedge hclk);
        io_in[0] <= 1'b1;
        for (int i = 0; i < 20 && pwr.bod_check !== 1'b1; i++) step(1);
        chk({30'h0, pwr.bod_check, pwr.osc32k}, 32'h3);
        @(posedge hclk);
        bod_ok <= 1'b1;
        osc32m_stable <= 1'b1;
        wait_awake();
        rd(A_STATUS);
        chk(rv, 32'h41);
        rd(A_FLAGS);
        chk(rv, 32'h1);
        wr(A_FLAGS, 32'h1);
        wr(A_STATUS, 32'h40);
        rd(A_FLAGS);
        chk(rv, 32'h0);
        $display("test sleep io wake done");
    endtask : t_sleep_io

    task automatic t_disabled;
        wr(A_WAKE_EN, 32'h0);
        wr(A_CTRL, 32'h1);
        step(2);
        chk({31'h0, pwr.ram}, 32'h0);
        @(posedge hclk);
        io_in[1] <= 1'b1;
        step(20);
        chk({31'h0, cpu_reset_n}, 32'h0);
        rd(A_FLAGS);
        chk(rv, 32'h2);
        wr(A_WAKE_EN, 32'h2); // a pending flag once enabled must wake at once
        wait_awake();
        wr(A_FLAGS, 32'h2);
        wr(A_STATUS, 32'h40);
        $display("test disabled source done");
    endtask : t_disabled

    task automatic t_doze;
        wr(A_CTRL, 32'h4);
        step(2);
        chk({30'h0, cpu_halt, pwr.digital}, 32'h3);
        @(posedge hclk);
        irq_req <= 1'b1;
        for (int i = 0; i < 10 && cpu_halt !== 1'b0; i++) step(1);
        chk({31'h0, cpu_halt}, 32'h0);
        @(posedge hclk);
        irq_req <= 1'b0;
        $display("test doze done");
    endtask : t_doze

    task automatic t_timer;
        wr(A_TMR_BASE, 32'h3);
        wr(A_TMR_BASE + A_TMR_HI_OFS, 32'h0);
        strobe(0, 2);
        rd(A_TMR_BASE);
        chk(rv, 32'h1);
        strobe(0, 1);
        rd(A_FLAGS);
        chk(rv & 32'h10000, 32'h10000);
        strobe(0, 1); // the timer keeps running past its event and wraps over 35 bits
        rd(A_TMR_BASE);
        chk(rv, 32'hFFFFFFFF);
        rd(A_TMR_BASE + A_TMR_HI_OFS);
        chk(rv & 32'h7, 32'h7);
        wr(A_FLAGS, 32'h10000);
        $display("test wake timer done");
    endtask : t_timer

    task automatic t_pulse;
        wr(A_PC_BASE, 32'h2);
        wr(A_WAKE_EN, 32'h40000);
        wr(A_CTRL, 32'h21); // sleep with the 32k oscillator stopped
        step(2);
        chk({31'h0, pwr.osc32k}, 32'h0);
        strobe(1, 2);
        wait_awake();
        rd(A_PC_BASE);
        chk(rv, 32'h2);
        strobe(1, 1);
        rd(A_PC_BASE);
        chk(rv, 32'h3);
        wr(A_FLAGS, 32'h40000);
        wr(A_STATUS, 32'h40);
        $display("test pulse counter done");
    endtask : t_pulse

    task automatic t_cmp;
        logic [31:0] e;
        for (int k = 0; k < 4; k++) begin
            e = k | ((k % 3) << 2) | (((k + 1) % 3) << 4);
            wr(A_CMP, e);
            step(1);
            chk({20'h0, cmp_cfg}, e);
        end
        wr(A_CMP, 32'h45B); // first comparator on, rising edge, external pin
        @(posedge hclk);
        cmp_raw[0] <= 1'b1;
        step(8);
        rd(A_FLAGS);
        chk(rv & 32'h100000, 32'h100000);
        rd(A_STATUS);
        chk((rv >> 7) & 32'h3, 32'h1);
        wr(A_FLAGS, 32'h100000);
        $display("test comparator done");
    endtask : t_cmp

    task automatic t_deep;
        wr(A_WAKE_EN, 32'h4);
        wr(A_CTRL, 32'h2);
        step(2);
        chk({27'h0, pwr.digital, pwr.analog, pwr.ram, pwr.radio, pwr.osc32k}, 32'h0);
        @(posedge hclk);
        io_in[2] <= 1'b0;
        for (int i = 0; i < 20 && chip_reset_req !== 1'b1; i++) step(1);
        chk({31'h0, chip_reset_req}, 32'h1);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        step(1);
        chk({30'h0, chip_reset_req, pwr.digital}, 32'h1);
        $display("test deep sleep done");
    endtask : t_deep

    // ========================================================
    // verdict and hang guard; the ceiling is far above the expected run
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        step(1);
        t_reset();
        t_sleep_io();
        t_disabled();
        t_doze();
        t_timer();
        t_pulse();
        t_cmp();
        t_deep();
        end_of_test();
    end
endmodule : tb
